// [common/wiper_lut_pkg.sv]
package wiper_lut_pkg;

  // register offsets
  localparam logic [7:0] ADDR_INITIAL_VALUE   = 8'h00;
  localparam logic [7:0] ADDR_SHADOW_CONTROL  = 8'h02;
  localparam logic [7:0] ADDR_MODE_CONTROL    = 8'h03;
  localparam logic [7:0] ADDR_TABLE_POINTER   = 8'h08;
  localparam logic [7:0] ADDR_WIPER_VALUE     = 8'h09;
  localparam logic [7:0] ADDR_OVERRIDE_CTL    = 8'h0A;
  localparam logic [7:0] ADDR_THERMAL_RESULT  = 8'h0C;
  localparam logic [7:0] ADDR_SUPPLY_RESULT   = 8'h0E;
  localparam logic [7:0] ADDR_TABLE_FIRST     = 8'h80;
  localparam logic [7:0] ADDR_TABLE_LAST      = 8'hC7;

  // field positions
  localparam int SHADOW_BIT         = 7;
  localparam int UPDATE_MODE_BIT    = 0;
  localparam int ADDER_MODE_BIT     = 1;
  localparam int POINTER_MANUAL_BIT = 1;
  localparam int WIPER_MANUAL_BIT   = 2;

  // values after reset
  localparam logic [7:0] MODE_CONTROL_RST = 8'h01;
  localparam logic [7:0] POINTER_RST      = 8'h00;
  localparam logic [6:0] WIPER_RST        = 7'h00;
  localparam logic [7:0] OVERRIDE_RST     = 8'h00;
  localparam logic       SHADOW_RST       = 1'b0;

  // lookup table geometry and temperature banding
  localparam int          TABLE_SLOTS    = 72;
  localparam logic [6:0]  SLOT_LAST      = 7'd71;
  localparam logic [8:0]  TEMP_BAND_BIAS = 9'd41;
  localparam logic [6:0]  WIPER_MAX      = 7'h7F;

  // conversion frame timing at the 25 MHz system clock
  localparam int CLK_MHZ            = 25;
  localparam int CONV_PERIOD_US     = 10000;
  localparam int CONV_PERIOD_CYCLES = CONV_PERIOD_US * CLK_MHZ;

endpackage

// [src/frame_timer.sv]
`timescale 1ns/1ps
module frame_timer
  import wiper_lut_pkg::*;
#(
  parameter int PERIOD_CYCLES = CONV_PERIOD_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      tick
);
  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);

  logic [CW-1:0] count_r;

  // free count while running, restart from zero when stopped
  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      count_r <= '0;
    end else if (count_r == LAST) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + CW'(1);
    end
  end

  // one pulse at the end of every frame period
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (count_r == LAST);
    end
  end
endmodule

// [src/wiper_calc.sv]
`timescale 1ns/1ps
module wiper_calc
  import wiper_lut_pkg::*;
(
  input  wire logic [7:0] temp,
  input  wire logic [7:0] entry,
  input  wire logic [6:0] initial_value,
  input  wire logic       adder,
  output logic      [6:0] slot,
  output logic      [6:0] wiper_nxt
);
  logic signed [8:0] biased;
  logic signed [8:0] sum;
  logic        [8:0] shifted;

  // two-degree bands, clamped to first and last slot
  always_comb begin
    biased  = $signed({temp[7], temp}) + $signed(TEMP_BAND_BIAS);
    shifted = 9'($unsigned(biased) >> 1);
    if (biased < 0) begin
      slot = 7'd0;
    end else if (shifted > {2'b00, SLOT_LAST}) begin
      slot = SLOT_LAST;
    end else begin
      slot = shifted[6:0];
    end
  end

  // direct entry or saturated sum with the initial value
  always_comb begin
    sum = $signed({2'b00, initial_value}) + $signed({{2{entry[6]}}, entry[6:0]});
    if (!adder) begin
      wiper_nxt = entry[7] ? WIPER_MAX : entry[6:0];
    end else if (sum < 0) begin
      wiper_nxt = 7'd0;
    end else if (sum > $signed({2'b00, WIPER_MAX})) begin
      wiper_nxt = WIPER_MAX;
    end else begin
      wiper_nxt = sum[6:0];
    end
  end
endmodule

// [src/wiper_lut_control_regs.sv]
// Functional notes
// - update mode 0: wiper loads initial value at power-up, results frozen
// - update mode 1: wiper set by host pointer/wiper writes or lookup path
// - adder bit picks lookup value alone or lookup plus initial value
// - mode control writes go to nonvolatile copy unless shadow bit set; recalled at power-up
// - pointer always readable; host writes accepted only with pointer manual set
// - pointer reads zero after power-on until the first frame ends
// - wiper auto-filled from lookup, always readable, host writes need wiper manual
// - wiper is a seven-bit unsigned quantity
// - update mode 1 refreshes wiper per frame; mode 0 holds initial-value writes
// - wiper manual bit selects automatic loading or host programming of wiper
// - pointer manual bit selects per-conversion pointer update or host writes
// - thermal result is signed degrees, refreshed per frame only in update mode
// - supply result is refreshed per frame only in update mode
// - compensation table holds one nonvolatile byte per temperature slot
// - table entries unsigned 8-bit without adder, signed 7-bit with adder
// - shadow bit 0: initial-value writes hit wiper and nonvolatile copy; 1: wiper only
`timescale 1ns/1ps
module wiper_lut_control_regs
  import wiper_lut_pkg::*;
#(
  parameter int PERIOD_CYCLES = CONV_PERIOD_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] nv_ivr,
  input  wire logic [7:0] nv_mode,
  output logic            nv_wr,
  output logic      [7:0] nv_wr_addr,
  output logic      [7:0] nv_wr_data,
  input  wire logic [7:0] temp_sample,
  input  wire logic [7:0] supply_sample,
  output logic            conv_start,
  output logic      [6:0] wiper_out
);

  // control and data registers
  logic       boot_r;
  logic       shadow_r;
  logic [1:0] mode_r;
  logic [2:1] override_r;
  logic [7:0] ivr_r;
  logic [7:0] pointer_r;
  logic [6:0] wiper_r;
  logic [7:0] thermal_r;
  logic [7:0] supply_r;
  logic       ptr_stage_r;
  logic       wip_stage_r;
  logic [7:0] table_mem [TABLE_SLOTS];

  // decoded controls
  logic       update_mode;
  logic       adder_mode;
  logic       pointer_manual;
  logic       wiper_manual;
  logic       frame_tick;
  logic       table_hit;
  logic [6:0] table_index;
  logic [6:0] ptr_clamped;
  logic [7:0] table_output_value;
  logic [6:0] calc_slot;
  logic [6:0] calc_wiper;

  assign update_mode    = mode_r[UPDATE_MODE_BIT];
  assign adder_mode     = mode_r[ADDER_MODE_BIT] && update_mode;
  assign pointer_manual = override_r[POINTER_MANUAL_BIT] && update_mode;
  assign wiper_manual   = override_r[WIPER_MANUAL_BIT] && update_mode;
  assign wiper_out      = wiper_r;

  // table window decode and host-side index
  assign table_hit   = (reg_addr >= ADDR_TABLE_FIRST) && (reg_addr <= ADDR_TABLE_LAST);
  assign table_index = 7'(reg_addr - ADDR_TABLE_FIRST);

  // pointer values beyond the last slot address the last slot
  assign ptr_clamped = (pointer_r > {1'b0, SLOT_LAST}) ? SLOT_LAST : pointer_r[6:0];
  assign table_output_value = table_mem[ptr_clamped];

  frame_timer #(
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (update_mode && !boot_r),
    .tick    (frame_tick)
  );

  wiper_calc u_calc (
    .temp      (thermal_r),
    .entry     (table_output_value),
    .initial_value       (ivr_r[6:0]),
    .adder     (adder_mode),
    .slot      (calc_slot),
    .wiper_nxt (calc_wiper)
  );

  // conversion request to the converter, one per frame
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= frame_tick;
    end
  end

  // power-up recall runs in the first cycle after reset release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  // shadow enable, volatile, clear at power-up
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shadow_r <= SHADOW_RST;
    end else if (reg_wr && reg_addr == ADDR_SHADOW_CONTROL) begin
      shadow_r <= reg_wdata[SHADOW_BIT];
    end
  end

  // mode control: recalled from the nonvolatile copy, then host writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r <= MODE_CONTROL_RST[1:0];
    end else if (boot_r) begin
      mode_r <= nv_mode[1:0];
    end else if (reg_wr && reg_addr == ADDR_MODE_CONTROL) begin
      mode_r <= reg_wdata[1:0];
    end
  end

  // manual override bits; bit 0 is not stored
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      override_r <= OVERRIDE_RST[2:1];
    end else if (reg_wr && reg_addr == ADDR_OVERRIDE_CTL) begin
      override_r <= reg_wdata[2:1];
    end
  end

  // volatile image of the initial value
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ivr_r <= 8'h00;
    end else if (boot_r) begin
      ivr_r <= nv_ivr;
    end else if (reg_wr && reg_addr == ADDR_INITIAL_VALUE && !shadow_r) begin
      ivr_r <= reg_wdata;
    end
  end

  // nonvolatile write requests for the initial value, mode control and table
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      nv_wr      <= 1'b0;
      nv_wr_addr <= 8'h00;
      nv_wr_data <= 8'h00;
    end else begin
      nv_wr      <= 1'b0;
      if (reg_wr && !boot_r) begin
        if (reg_addr == ADDR_INITIAL_VALUE && !shadow_r) begin
          nv_wr      <= 1'b1;
          nv_wr_addr <= reg_addr;
          nv_wr_data <= reg_wdata;
        end else if (reg_addr == ADDR_MODE_CONTROL && !shadow_r) begin
          nv_wr      <= 1'b1;
          nv_wr_addr <= reg_addr;
          nv_wr_data <= {6'b000000, reg_wdata[1:0]};
        end else if (table_hit) begin
          nv_wr      <= 1'b1;
          nv_wr_addr <= reg_addr;
          nv_wr_data <= reg_wdata;
        end
      end
    end
  end

  // compensation table storage, one byte per slot
  always_ff @(posedge sys_clk) begin
    if (reg_wr && table_hit) begin
      table_mem[table_index] <= reg_wdata;
    end
  end

  // converter results latched once per frame, only in update mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      thermal_r <= 8'h00;
      supply_r  <= 8'h00;
    end else if (frame_tick && update_mode) begin
      thermal_r <= temp_sample;
      supply_r  <= supply_sample;
    end
  end

  // frame sequence: results, then pointer, then wiper
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_stage_r <= 1'b0;
    end else begin
      ptr_stage_r <= frame_tick && update_mode;
    end
  end

  // wiper reload after a pointer step or a host pointer write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wip_stage_r <= 1'b0;
    end else begin
      wip_stage_r <= (ptr_stage_r ||
                      (reg_wr && reg_addr == ADDR_TABLE_POINTER && pointer_manual))
                     && update_mode;
    end
  end

  // table pointer: zero until the first frame, then automatic or manual
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pointer_r <= POINTER_RST;
    end else if (reg_wr && reg_addr == ADDR_TABLE_POINTER && pointer_manual) begin
      pointer_r <= reg_wdata;
    end else if (ptr_stage_r && !pointer_manual) begin
      pointer_r <= {1'b0, calc_slot};
    end
  end

  // wiper: power-up initial value, host writes, or frame refresh
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wiper_r <= WIPER_RST;
    end else if (boot_r) begin
      wiper_r <= nv_ivr[6:0];
    end else if (reg_wr && reg_addr == ADDR_INITIAL_VALUE) begin
      wiper_r <= reg_wdata[6:0];
    end else if (reg_wr && reg_addr == ADDR_WIPER_VALUE && wiper_manual) begin
      wiper_r <= reg_wdata[6:0];
    end else if (wip_stage_r && !wiper_manual) begin
      wiper_r <= calc_wiper;
    end
  end

  // registered read data; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (table_hit) begin
        reg_rdata <= table_mem[table_index];
      end else begin
        unique case (reg_addr)
          ADDR_INITIAL_VALUE:  reg_rdata <= shadow_r ? {1'b0, wiper_r} : ivr_r;
          ADDR_SHADOW_CONTROL: reg_rdata <= {shadow_r, 7'h00};
          ADDR_MODE_CONTROL:   reg_rdata <= {6'h00, mode_r};
          ADDR_TABLE_POINTER:  reg_rdata <= pointer_r;
          ADDR_WIPER_VALUE:    reg_rdata <= {1'b0, wiper_r};
          ADDR_OVERRIDE_CTL:   reg_rdata <= {5'h00, override_r, 1'b0};
          ADDR_THERMAL_RESULT: reg_rdata <= thermal_r;
          ADDR_SUPPLY_RESULT:  reg_rdata <= supply_r;
          default:             reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// [tb/wiper_lut_control_regs_chk.sv]
`timescale 1ns/1ps
module wiper_lut_chk
  import wiper_lut_pkg::*;
#(
  parameter int PERIOD_CYCLES = CONV_PERIOD_CYCLES
) (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] nv_ivr,
  input wire logic [7:0] nv_mode,
  input wire logic       nv_wr,
  input wire logic [7:0] nv_wr_addr,
  input wire logic [7:0] nv_wr_data,
  input wire logic [7:0] temp_sample,
  input wire logic [7:0] supply_sample,
  input wire logic       conv_start,
  input wire logic [6:0] wiper_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // no second conversion close behind the first
  sequence s_quiet;
    !conv_start [*8];
  endsequence
  // register port and frame relations
  a_read_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_frame_gap: assert property (conv_start |=> s_quiet)
    else $error("conversions too close");
  a_nv_source: assert property (nv_wr |-> $past(reg_wr) && nv_wr_addr == $past(reg_addr) &&
    nv_wr_data == $past(reg_wdata)) else $error("nv write without host write");
  a_ivr_write: assert property (reg_wr && reg_addr == ADDR_INITIAL_VALUE && !conv_start &&
    !$past(conv_start) && !$past(reg_wr) |=> wiper_out == $past(reg_wdata[6:0]))
    else $error("initial value write missed wiper");
  a_wiper_cause: assert property ($changed(wiper_out) |-> $past(srst, 2) || $past(reg_wr) ||
    $past(reg_wr, 2) || $past(conv_start, 2)) else $error("wiper moved with no cause");
  a_table_nv: assert property (reg_wr && reg_addr >= ADDR_TABLE_FIRST &&
    reg_addr <= ADDR_TABLE_LAST |=> nv_wr && nv_wr_addr == $past(reg_addr))
    else $error("table write not stored");
  a_mode_rsvd: assert property (reg_rd && reg_addr == ADDR_MODE_CONTROL |=>
    reg_rdata[7:2] == 6'h00) else $error("mode reserved bits set");
  a_override_rsvd: assert property (reg_rd && reg_addr == ADDR_OVERRIDE_CTL |=>
    reg_rdata[0] == 1'b0 && reg_rdata[7:3] == 5'h00) else $error("override reserved bits set");
endmodule

// [tb/nv_adc_model.sv]
`timescale 1ns/1ps
module nv_adc_model #(
  parameter logic [7:0] IVR_INIT  = 8'h15,
  parameter logic [7:0] MODE_INIT = 8'h01
) (
  input  wire logic       sys_clk,
  input  wire logic       nv_wr,
  input  wire logic [7:0] nv_wr_addr,
  input  wire logic [7:0] nv_wr_data,
  input  wire logic [7:0] temp_set,
  input  wire logic [7:0] supply_set,
  output logic      [7:0] nv_ivr,
  output logic      [7:0] nv_mode,
  output logic      [7:0] temp_sample,
  output logic      [7:0] supply_sample
);
  // converter codes follow the conditions the bench sets
  assign temp_sample   = temp_set;
  assign supply_sample = supply_set;
  // nonvolatile copies start from stored values
  initial begin
    nv_ivr  = IVR_INIT;
    nv_mode = MODE_INIT;
  end
  // nonvolatile copies take the initial-value and mode control writes the block issues; table writes are ignored
  always @(posedge sys_clk) begin
    if (nv_wr && nv_wr_addr == 8'h00) nv_ivr <= nv_wr_data;
    if (nv_wr && nv_wr_addr == 8'h03) nv_mode <= nv_wr_data;
  end
endmodule

// [tb/wiper_lut_control_regs_tb.sv]
`timescale 1ns/1ps
module wiper_lut_control_regs_tb;
  import wiper_lut_pkg::*;
  localparam int P = 20;
  logic       sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, nv_wr, conv_start;
  logic [7:0] reg_addr = 0, reg_wdata = 0, temp_set = 8'h19, supply_set = 8'h9C;
  logic [7:0] reg_rdata, nv_ivr, nv_mode, nv_wr_addr, nv_wr_data, temp_sample, supply_sample;
  logic [6:0] wiper_out;
  logic [7:0] tbl [72];
  logic [7:0] temps [3] = '{8'h19, 8'hC4, 8'h78};
  logic [7:0] slots [3] = '{8'h21, 8'h00, 8'h47};
  int         error_cnt = 0, checks_done = 0;
  always #20 sys_clk = ~sys_clk;
  wiper_lut_control_regs #(.PERIOD_CYCLES(P)) i_dut (.sys_clk, .srst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .nv_ivr, .nv_mode, .nv_wr, .nv_wr_addr, .nv_wr_data,
    .temp_sample, .supply_sample, .conv_start, .wiper_out);
  nv_adc_model i_nv (.sys_clk, .nv_wr, .nv_wr_addr, .nv_wr_data, .temp_set, .supply_set,
    .nv_ivr, .nv_mode, .temp_sample, .supply_sample);
  // compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one byte write on the register port
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 0;
  endtask
  // one byte read, data checked the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 0;
    chk(reg_rdata, exp);
  endtask
  task frames(input int n);
    repeat (n * (P + 2)) @(negedge sys_clk);
  endtask
  task stop_test;
    $display("Errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (6000) @(posedge sys_clk);
    error_cnt++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    srst = 0;
    repeat (2) @(negedge sys_clk);
    chk({1'b0, wiper_out}, 8'h15);
    rd(8'h03, 8'h01);
    rd(8'h08, 8'h00);
    rd(8'h0A, 8'h00);
    rd(8'h01, 8'h00);
    for (int i = 0; i < 72; i++) begin
      tbl[i] = 8'h10 + 8'(i);
      wr(8'h80 + 8'(i), tbl[i]);
    end
    rd(8'hA1, tbl[33]);
    for (int k = 0; k < 3; k++) begin
      temp_set = temps[k];
      frames(2);
      rd(8'h08, slots[k]);
      chk({1'b0, wiper_out}, tbl[slots[k]]);
      rd(8'h0C, temps[k]);
      rd(8'h0E, 8'h9C);
    end
    // adder path and its clamp
    temp_set = 8'h19;
    wr(8'h03, 8'h03);
    frames(2);
    chk({1'b0, wiper_out}, 8'h46);
    wr(8'hA1, 8'h60);
    frames(2);
    chk({1'b0, wiper_out}, 8'h00);
    wr(8'hA1, tbl[33]);
    // manual pointer and wiper
    wr(8'h03, 8'h01);
    wr(8'h0A, 8'h02);
    wr(8'h08, 8'h05);
    rd(8'h08, 8'h05);
    chk({1'b0, wiper_out}, tbl[5]);
    frames(2);
    rd(8'h08, 8'h05);
    wr(8'h0A, 8'h06);
    wr(8'h09, 8'h2A);
    frames(2);
    rd(8'h09, 8'h2A);
    chk({1'b0, wiper_out}, 8'h2A);
    wr(8'h0A, 8'h00);
    frames(2);
    wr(8'h09, 8'h77);
    rd(8'h09, tbl[33]);
    wr(8'h08, 8'h03);
    rd(8'h08, 8'h21);
    // update mode 0 freezes results and pointer
    wr(8'h03, 8'h00);
    temp_set = 8'h32;
    supply_set = 8'h11;
    frames(2);
    rd(8'h0C, 8'h19);
    rd(8'h0E, 8'h9C);
    rd(8'h08, 8'h21);
    wr(8'h00, 8'h33);
    chk({1'b0, wiper_out}, 8'h33);
    rd(8'h00, 8'h33);
    chk(nv_ivr, 8'h33);
    wr(8'h02, 8'h80);
    wr(8'h00, 8'h44);
    rd(8'h00, 8'h44);
    chk(nv_ivr, 8'h33);
    wr(8'h03, 8'h02);
    rd(8'h03, 8'h02);
    chk(nv_mode, 8'h00);
    wr(8'h0C, 8'h55);
    rd(8'h0C, 8'h19);
    // second reset in mid-run recalls the stored copies
    srst = 1;
    repeat (4) @(negedge sys_clk);
    srst = 0;
    repeat (2) @(negedge sys_clk);
    chk({1'b0, wiper_out}, 8'h33);
    rd(8'h03, 8'h00);
    rd(8'h08, 8'h00);
    stop_test;
  end
endmodule
bind wiper_lut_control_regs wiper_lut_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) i_chk (.sys_clk,
  .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .nv_ivr, .nv_mode, .nv_wr,
  .nv_wr_addr, .nv_wr_data, .temp_sample, .supply_sample, .conv_start, .wiper_out);
